// file: design/tuner_pins_pkg.sv
package tuner_pins_pkg;

    // Clock and timing.
    localparam int CLK_PERIOD_NS   = 50;
    localparam int IRQ_PULSE_US    = 5000;
    localparam int POWERUP_MAX_US  = 110000;
    localparam int IRQ_PULSE_CYCLES =
        (IRQ_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYCLES  = (POWERUP_MAX_US * 1000) / CLK_PERIOD_NS;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // Register bus.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [7:0] ADDR_POWER      = 8'h02;
    localparam logic [7:0] ADDR_CONFIG     = 8'h04;
    localparam logic [7:0] ADDR_STATUS     = 8'h0A;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0E;

    // Power register.
    localparam int POWER_ENABLE_BIT = 0;

    // Configuration register: three two-bit pin fields and enables.
    localparam int PIN_FIELD_W      = 2;
    localparam int PIN_FIELDS_W     = 6;
    localparam int SEEK_TUNE_IRQ_ENABLE_BIT       = 14;
    localparam int RDS_IRQ_ENABLE_BIT       = 15;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;
    localparam logic [1:0] FN_INPUT      = 2'h0;
    localparam logic [1:0] FN_SPECIAL    = 2'h1;
    localparam logic [1:0] FN_DRIVE_LOW  = 2'h2;
    localparam logic [1:0] FN_DRIVE_HIGH = 2'h3;

    // Status register.
    localparam int ST_PIN_LSB   = 0;
    localparam int ST_SEEK_BIT  = 3;
    localparam int ST_RDS_BIT   = 4;
    localparam int ST_STEREO_BIT = 5;
    localparam int ST_POWER_BIT = 6;
    localparam int ST_STRAP_LSB = 7;
    localparam int ST_3WIRE_BIT = 9;
    localparam int ST_STRAPPED_BIT = 10;

    // Strap code {pin three, pin one} that selects the three-wire interface.
    localparam logic [1:0] STRAP_3WIRE = 2'h1;

    // Interrupt status and mask layout.
    localparam int IRQ_W         = 3;
    localparam int IRQ_SEEK_BIT  = 0;
    localparam int IRQ_RDS_BIT   = 1;
    localparam int IRQ_POWER_BIT = 2;

    typedef enum logic [1:0] {
        PWR_OFF    = 2'b00,
        PWR_RISING = 2'b01,
        PWR_ON     = 2'b10
    } power_state_type;

endpackage

// file: design/pin_sample_if.sv
`timescale 1ns/10ps
`default_nettype none
interface pin_sample_if;
    logic [2:0] raw;
    logic [2:0] level;
    modport user   (output raw, input level);
    modport syncer (input raw, output level);
endinterface
`default_nettype wire

// file: design/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic nrst_in,
    // Pin levels.
    pin_sample_if.syncer pins
);
    logic [2:0] stage_one_r;
    logic [2:0] stage_two_r;

    // Two flops before any logic sees a pin.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            stage_one_r <= 3'h0;
            stage_two_r <= 3'h0;
        end else begin
            stage_one_r <= pins.raw;
            stage_two_r <= stage_one_r;
        end
    end

    assign pins.level = stage_two_r;
endmodule // pin_sync
`default_nettype wire

// file: design/irq_pulse_gen.sv
`timescale 1ns/10ps
`default_nettype none
module irq_pulse_gen #(
    parameter int PULSE_CYCLES = tuner_pins_pkg::IRQ_PULSE_CYCLES
) (
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic nrst_in,
    // Event in, pulse out.
    input  wire logic trigger_in,
    output logic      active_out
);
    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);
    localparam logic [CNT_W-1:0] LOAD = CNT_W'(PULSE_CYCLES - 1);

    logic [CNT_W-1:0] cnt_r;
    logic             active_r;

    // A new event restarts the full low time.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cnt_r    <= '0;
            active_r <= 1'b0;
        end else if (trigger_in) begin
            cnt_r    <= LOAD;
            active_r <= 1'b1;
        end else if (active_r) begin
            if (cnt_r == '0) begin
                active_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r - CNT_W'(1);
            end
        end
    end

    assign active_out = active_r;

    AST_PULSE_LOAD: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        trigger_in |=> active_r && cnt_r == LOAD)
        else $error("Pulse did not load its full length.");

    AST_PULSE_END: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        $fell(active_r) |-> $past(cnt_r) == '0)
        else $error("Pulse ended before its count ran out.");
endmodule // irq_pulse_gen
`default_nettype wire

// file: design/tuner_multifunction_pins.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - At reset release the levels on pins one and three are latched to pick the two- or three-wire control interface, and the host keeps them steady then.
// - After powerup each of the three pins can be set as a general input or output.
// - Pin two can be an interrupt request for seek/tune done or RDS ready, and pin three a stereo/mono indicator.
// - The pin functions come from the six low bits of the configuration register at 04h.
// - The pull-down on pin three is on only while reset is low.
// - General pin input and output work regardless of supplies and of the power enable bit.
// - With seek/tune interrupts on and pin two in interrupt mode, pin two goes low for 5 ms whenever the done flag sets.
// - With RDS interrupts on and pin two in interrupt mode, pin two goes low at least 5 ms when a valid group arrives.
// - Writing the power enable bit to one from powerdown finishes powerup within 110 ms.
// - A seek/tune interrupt enabled before powerup still fires when the initial tune finishes.
module tuner_multifunction_pins #(
    parameter int IRQ_PULSE_CYCLES = tuner_pins_pkg::IRQ_PULSE_CYCLES,
    parameter int POWERUP_CYCLES   = tuner_pins_pkg::POWERUP_CYCLES
) (
    // Clock and reset.
    input  wire logic        ref_clk_in,
    input  wire logic        nrst_in,
    // Register port.
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [15:0] reg_rdata_out,
    // Tuner core status.
    input  wire logic        seek_tune_done_flag_in,
    input  wire logic        rds_group_ready_flag_in,
    input  wire logic        stereo_indicator_flag_in,
    // Multi-function pins.
    input  wire logic        multi_pin_one_in,
    output logic             multi_pin_one_out,
    output logic             multi_pin_one_oe_out,
    input  wire logic        multi_pin_two_in,
    output logic             multi_pin_two_out,
    output logic             multi_pin_two_oe_out,
    input  wire logic        multi_pin_three_in,
    output logic             multi_pin_three_out,
    output logic             multi_pin_three_oe_out,
    output logic             pin_three_pulldown_out,
    // Interface select, power and interrupt.
    output logic             interface_3wire_out,
    output logic             power_ready_out,
    output logic             irq_out
);
    localparam int PWR_W = $clog2(POWERUP_CYCLES + 1);
    localparam logic [PWR_W-1:0] PWR_LOAD = PWR_W'(POWERUP_CYCLES - 1);

    pin_sample_if pins ();

    logic [15:0]     config_r;
    logic            power_enable_r;
    logic            power_ready_r;
    tuner_pins_pkg::power_state_type pwr_state_r;
    logic [PWR_W-1:0] pwr_cnt_r;
    logic [1:0]      strap_cnt_r;
    logic            strapped_r;
    logic [1:0]      strap_r;
    logic            iface_3wire_r;
    logic            pulldown_r;
    logic            seek_prev_r;
    logic            rds_prev_r;
    logic [2:0]      irq_status_r;
    logic [2:0]      irq_mask_r;
    logic [2:0]      irq_set;
    logic            irq_r;
    logic [15:0]     rdata_r;
    logic [2:0]      pin_out_r;
    logic [2:0]      pin_oe_r;
    logic            seek_rise;
    logic            rds_rise;
    logic            pulse_trigger;
    logic            pulse_active;
    logic            pwr_done_evt;
    logic            wr_power;
    logic            wr_config;
    logic            wr_irq_status;
    logic            wr_irq_mask;

    assign pins.raw = {multi_pin_three_in, multi_pin_two_in, multi_pin_one_in};

    pin_sync u_sync (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .pins       (pins.syncer)
    );

    assign wr_power      = reg_wr_in && reg_addr_in == tuner_pins_pkg::ADDR_POWER;
    assign wr_config     = reg_wr_in && reg_addr_in == tuner_pins_pkg::ADDR_CONFIG;
    assign wr_irq_status = reg_wr_in &&
                           reg_addr_in == tuner_pins_pkg::ADDR_IRQ_STATUS;
    assign wr_irq_mask   = reg_wr_in &&
                           reg_addr_in == tuner_pins_pkg::ADDR_IRQ_MASK;

    // Configuration register with pin fields and interrupt enables.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            config_r <= tuner_pins_pkg::CONFIG_RESET;
        end else if (wr_config) begin
            config_r <= reg_wdata_in;
        end
    end

    // Pull-down on pin three is held only during reset.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pulldown_r <= 1'b1;
        end else begin
            pulldown_r <= 1'b0;
        end
    end

    // Straps are taken once the synchronizer has settled after release.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            strap_cnt_r   <= 2'h0;
            strapped_r    <= 1'b0;
            strap_r       <= 2'h0;
            iface_3wire_r <= 1'b0;
        end else if (!strapped_r) begin
            if (strap_cnt_r == tuner_pins_pkg::STRAP_SETTLE) begin
                strapped_r    <= 1'b1;
                strap_r       <= {pins.level[2], pins.level[0]};
                iface_3wire_r <= {pins.level[2], pins.level[0]} ==
                                 tuner_pins_pkg::STRAP_3WIRE;
            end else begin
                strap_cnt_r <= strap_cnt_r + 2'h1;
            end
        end
    end

    // Power sequencing: enable from off starts the bounded powerup count.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            power_enable_r <= 1'b0;
            pwr_state_r    <= tuner_pins_pkg::PWR_OFF;
            pwr_cnt_r      <= '0;
            power_ready_r  <= 1'b0;
        end else begin
            if (wr_power) begin
                power_enable_r <= reg_wdata_in[tuner_pins_pkg::POWER_ENABLE_BIT];
            end
            unique case (pwr_state_r)
                tuner_pins_pkg::PWR_OFF: begin
                    if (wr_power &&
                        reg_wdata_in[tuner_pins_pkg::POWER_ENABLE_BIT]) begin
                        pwr_state_r <= tuner_pins_pkg::PWR_RISING;
                        pwr_cnt_r   <= PWR_LOAD;
                    end
                end
                tuner_pins_pkg::PWR_RISING: begin
                    if (wr_power &&
                        !reg_wdata_in[tuner_pins_pkg::POWER_ENABLE_BIT]) begin
                        pwr_state_r <= tuner_pins_pkg::PWR_OFF;
                    end else if (pwr_cnt_r == '0) begin
                        pwr_state_r <= tuner_pins_pkg::PWR_ON;
                        power_ready_r <= 1'b1;
                    end else begin
                        pwr_cnt_r <= pwr_cnt_r - PWR_W'(1);
                    end
                end
                tuner_pins_pkg::PWR_ON: begin
                    if (wr_power &&
                        !reg_wdata_in[tuner_pins_pkg::POWER_ENABLE_BIT]) begin
                        pwr_state_r <= tuner_pins_pkg::PWR_OFF;
                        power_ready_r <= 1'b0;
                    end
                end
                default: begin
                    pwr_state_r <= tuner_pins_pkg::PWR_OFF;
                    power_ready_r <= 1'b0;
                end
            endcase
        end
    end

    assign pwr_done_evt = pwr_state_r == tuner_pins_pkg::PWR_RISING &&
                          pwr_cnt_r == '0 &&
                          !(wr_power &&
                            !reg_wdata_in[tuner_pins_pkg::POWER_ENABLE_BIT]);

    // Rising edges of the seek/tune and RDS flags are interrupt events.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            seek_prev_r <= 1'b0;
            rds_prev_r  <= 1'b0;
        end else begin
            seek_prev_r <= seek_tune_done_flag_in;
            rds_prev_r  <= rds_group_ready_flag_in;
        end
    end

    assign seek_rise = seek_tune_done_flag_in && !seek_prev_r;
    assign rds_rise  = rds_group_ready_flag_in && !rds_prev_r;

    // The pin pulse is not gated by power state, so an early enable fires.
    assign pulse_trigger =
        config_r[2*tuner_pins_pkg::PIN_FIELD_W-1:tuner_pins_pkg::PIN_FIELD_W]
            == tuner_pins_pkg::FN_SPECIAL &&
        ((seek_rise && config_r[tuner_pins_pkg::SEEK_TUNE_IRQ_ENABLE_BIT]) ||
         (rds_rise && config_r[tuner_pins_pkg::RDS_IRQ_ENABLE_BIT]));

    irq_pulse_gen #(
        .PULSE_CYCLES (IRQ_PULSE_CYCLES)
    ) u_pulse (
        .ref_clk_in (ref_clk_in),
        .nrst_in    (nrst_in),
        .trigger_in (pulse_trigger),
        .active_out (pulse_active)
    );

    // Pin drivers, one per pin, never gated by power state.
    generate
        for (genvar i = 0; i < 3; i++) begin : g_pin
            logic [1:0] fn;
            assign fn = config_r[i*tuner_pins_pkg::PIN_FIELD_W +:
                                 tuner_pins_pkg::PIN_FIELD_W];
            always_ff @(posedge ref_clk_in or negedge nrst_in) begin
                if (!nrst_in) begin
                    pin_out_r[i] <= 1'b0;
                    pin_oe_r[i]  <= 1'b0;
                end else begin
                    unique case (fn)
                        tuner_pins_pkg::FN_INPUT: begin
                            pin_out_r[i] <= 1'b0;
                            pin_oe_r[i]  <= 1'b0;
                        end
                        tuner_pins_pkg::FN_DRIVE_LOW: begin
                            pin_out_r[i] <= 1'b0;
                            pin_oe_r[i]  <= 1'b1;
                        end
                        tuner_pins_pkg::FN_DRIVE_HIGH: begin
                            pin_out_r[i] <= 1'b1;
                            pin_oe_r[i]  <= 1'b1;
                        end
                        tuner_pins_pkg::FN_SPECIAL: begin
                            if (i == 1) begin
                                pin_out_r[i] <= !pulse_active;
                                pin_oe_r[i]  <= 1'b1;
                            end else if (i == 2) begin
                                pin_out_r[i] <= stereo_indicator_flag_in;
                                pin_oe_r[i]  <= 1'b1;
                            end else begin
                                pin_out_r[i] <= 1'b0;
                                pin_oe_r[i]  <= 1'b0;
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Sticky interrupt status; a set in the clearing cycle wins.
    assign irq_set[tuner_pins_pkg::IRQ_SEEK_BIT]  = seek_rise;
    assign irq_set[tuner_pins_pkg::IRQ_RDS_BIT]   = rds_rise;
    assign irq_set[tuner_pins_pkg::IRQ_POWER_BIT] = pwr_done_evt;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_status_r <= 3'h0;
            irq_mask_r   <= 3'h0;
            irq_r        <= 1'b0;
        end else begin
            irq_status_r <= (irq_status_r &
                             ~(wr_irq_status ? reg_wdata_in[2:0] : 3'h0)) |
                            irq_set;
            if (wr_irq_mask) begin
                irq_mask_r <= reg_wdata_in[2:0];
            end
            irq_r <= |(irq_status_r & irq_mask_r);
        end
    end

    // Read data stands in the cycle after the read strobe.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd_in) begin
            rdata_r <= 16'h0000;
            unique case (reg_addr_in)
                tuner_pins_pkg::ADDR_POWER: begin
                    rdata_r[tuner_pins_pkg::POWER_ENABLE_BIT] <= power_enable_r;
                end
                tuner_pins_pkg::ADDR_CONFIG: begin
                    rdata_r <= config_r;
                end
                tuner_pins_pkg::ADDR_STATUS: begin
                    rdata_r[tuner_pins_pkg::ST_PIN_LSB +: 3] <= pins.level;
                    rdata_r[tuner_pins_pkg::ST_SEEK_BIT]   <= seek_tune_done_flag_in;
                    rdata_r[tuner_pins_pkg::ST_RDS_BIT]    <= rds_group_ready_flag_in;
                    rdata_r[tuner_pins_pkg::ST_STEREO_BIT] <= stereo_indicator_flag_in;
                    rdata_r[tuner_pins_pkg::ST_POWER_BIT]  <=
                        pwr_state_r == tuner_pins_pkg::PWR_ON;
                    rdata_r[tuner_pins_pkg::ST_STRAP_LSB +: 2] <= strap_r;
                    rdata_r[tuner_pins_pkg::ST_3WIRE_BIT]    <= iface_3wire_r;
                    rdata_r[tuner_pins_pkg::ST_STRAPPED_BIT] <= strapped_r;
                end
                tuner_pins_pkg::ADDR_IRQ_STATUS: begin
                    rdata_r[2:0] <= irq_status_r;
                end
                tuner_pins_pkg::ADDR_IRQ_MASK: begin
                    rdata_r[2:0] <= irq_mask_r;
                end
                default: begin
                    rdata_r <= 16'h0000;
                end
            endcase
        end
    end

    assign reg_rdata_out          = rdata_r;
    assign multi_pin_one_out      = pin_out_r[0];
    assign multi_pin_one_oe_out   = pin_oe_r[0];
    assign multi_pin_two_out      = pin_out_r[1];
    assign multi_pin_two_oe_out   = pin_oe_r[1];
    assign multi_pin_three_out    = pin_out_r[2];
    assign multi_pin_three_oe_out = pin_oe_r[2];
    assign pin_three_pulldown_out = pulldown_r;
    assign interface_3wire_out    = iface_3wire_r;
    assign power_ready_out        = power_ready_r;
    assign irq_out                = irq_r;

    AST_PULLDOWN_OFF: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        $past(nrst_in) |-> !pin_three_pulldown_out)
        else $error("Pull-down still on after reset release.");

    AST_STRAP_LATCH: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        $rose(strapped_r) |-> strap_r == {$past(pins.level[2]),
                                          $past(pins.level[0])})
        else $error("Strap levels not latched from pins.");

    AST_GPO_HIGH: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        config_r[1:0] == tuner_pins_pkg::FN_DRIVE_HIGH ##1
        config_r[1:0] == tuner_pins_pkg::FN_DRIVE_HIGH
        |-> multi_pin_one_out && multi_pin_one_oe_out)
        else $error("Pin one not driving high.");

    AST_GPI_RELEASE: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        $past(config_r[5:4]) == tuner_pins_pkg::FN_INPUT
        |-> !multi_pin_three_oe_out)
        else $error("Input pin three is being driven.");

    AST_STEREO_PIN: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        $past(config_r[5:4]) == tuner_pins_pkg::FN_SPECIAL
        |-> multi_pin_three_oe_out &&
            multi_pin_three_out == $past(stereo_indicator_flag_in))
        else $error("Pin three does not show stereo state.");

    AST_SEEK_IRQ_LOW: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        seek_rise && config_r[tuner_pins_pkg::SEEK_TUNE_IRQ_ENABLE_BIT] &&
        config_r[3:2] == tuner_pins_pkg::FN_SPECIAL ##1
        config_r[3:2] == tuner_pins_pkg::FN_SPECIAL
        |=> !multi_pin_two_out && multi_pin_two_oe_out)
        else $error("Pin two did not go low on seek done.");

    AST_RDS_IRQ_HOLD: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        $rose(pulse_active) |-> pulse_active [*8])
        else $error("Pin two pulse too short.");

    AST_POWERUP_DONE: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        pwr_state_r == tuner_pins_pkg::PWR_RISING && pwr_cnt_r == '0 &&
        !wr_power |=> power_ready_out)
        else $error("Powerup did not finish on time.");

    AST_IRQ_STICKY: assert property (@(posedge ref_clk_in)
        disable iff (!nrst_in)
        seek_rise |=> irq_status_r[tuner_pins_pkg::IRQ_SEEK_BIT])
        else $error("Seek event lost from status.");
endmodule // tuner_multifunction_pins
`default_nettype wire

// file: test/pin_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pin_host_model (
    // Design side.
    input  wire logic [2:0] dout_in,
    input  wire logic [2:0] oe_in,
    input  wire logic       pd_in,
    // Host side.
    input  wire logic [2:0] hdrv_in,
    input  wire logic [2:0] hval_in,
    // Resolved pins.
    output logic      [2:0] pin_out
);
    // A floating pin shows the inverse of the design's held value.
    always_comb begin
        pin_out = ~dout_in;
        pin_out = (hdrv_in & hval_in) | (~hdrv_in & pin_out);
        if (pd_in && !hdrv_in[2]) begin
            pin_out[2] = 1'h0;
        end
        pin_out = (oe_in & dout_in) | (~oe_in & pin_out);
    end
endmodule // pin_host_model
`default_nettype wire

// file: test/tuner_multifunction_pins_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tuner_multifunction_pins_tb;
    localparam int PW = 20;
    localparam int PU = 50;
    logic        clk = 1'h0, nrst = 1'h0, wr = 1'h0, rd = 1'h0;
    logic        seek = 1'h0, rds = 1'h0, ster = 1'h0;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic [2:0]  hdrv = 3'h5, hval = 3'h1;
    logic [15:0] rdat, v;
    logic [2:0]  pin, dout, oe;
    logic        pd, w3, prdy, irq;
    int          n_errors = 0, check_count = 0, n;
    always #25 clk = ~clk;
    tuner_multifunction_pins #(.IRQ_PULSE_CYCLES(PW), .POWERUP_CYCLES(PU))
    tuner_multifunction_pins_inst (
        .ref_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdat), .seek_tune_done_flag_in(seek),
        .rds_group_ready_flag_in(rds), .stereo_indicator_flag_in(ster),
        .multi_pin_one_in(pin[0]), .multi_pin_one_out(dout[0]),
        .multi_pin_one_oe_out(oe[0]), .multi_pin_two_in(pin[1]),
        .multi_pin_two_out(dout[1]), .multi_pin_two_oe_out(oe[1]),
        .multi_pin_three_in(pin[2]), .multi_pin_three_out(dout[2]),
        .multi_pin_three_oe_out(oe[2]), .pin_three_pulldown_out(pd),
        .interface_3wire_out(w3), .power_ready_out(prdy), .irq_out(irq));
    pin_host_model pin_host_model_inst (.dout_in(dout), .oe_in(oe),
        .pd_in(pd), .hdrv_in(hdrv), .hval_in(hval), .pin_out(pin));
    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'h0;
        rd <= 1'h0;
        #1 v = rdat;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        chk("pulldown", 16'h0001, {15'h0000, pd});
        nrst <= 1'h1;
        repeat (6) @(posedge clk);
        hdrv <= 3'h0;
        #1 chk("pulldown", 16'h0000, {15'h0000, pd});
        chk("3wire", 16'h0001, {15'h0000, w3});
        acc(1'h0, 8'h0A, 16'h0000);
        chk("strap", 16'h0680, v & 16'h0780);
        acc(1'h0, 8'h04, 16'h0000);
        chk("config", 16'h0000, v);
        acc(1'h0, 8'h20, 16'h0000);
        chk("unmapped", 16'h0000, v);
        $display("test reset done");
        acc(1'h1, 8'h04, 16'h003B);
        repeat (2) @(posedge clk);
        #1 chk("drive", 16'h003D, {10'h000, oe, pin});
        acc(1'h1, 8'h04, 16'h0000);
        hdrv <= 3'h7;
        hval <= 3'h6;
        repeat (4) @(posedge clk);
        acc(1'h0, 8'h0A, 16'h0000);
        chk("input", 16'h0006, {10'h000, oe, v[2:0]});
        hdrv <= 3'h0;
        acc(1'h1, 8'h04, 16'h0010);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            ster <= (i == 0);
            repeat (3) @(posedge clk);
            #1 chk("stereo", {14'h0000, 1'h1, ster}, {14'h0000, oe[2], pin[2]});
        end
        $display("test pins done");
        for (int k = 0; k < 3; k++) begin
            acc(1'h1, 8'h04, k == 0 ? 16'h4004 : k == 1 ? 16'h8004 : 16'h0004);
            @(posedge clk);
            seek <= (k != 1);
            rds <= (k == 1);
            n = 0;
            repeat (PW + 10) begin
                @(posedge clk);
                #1 n += !pin[1];
            end
            chk("pulse", (k == 2) ? 16'h0000 : 16'(PW), 16'(n));
            @(posedge clk);
            seek <= 1'h0;
            rds <= 1'h0;
        end
        acc(1'h0, 8'h0C, 16'h0000);
        chk("events", 16'h0003, v);
        acc(1'h1, 8'h0C, 16'h0007);
        acc(1'h1, 8'h0E, 16'h0004);
        acc(1'h1, 8'h02, 16'h0001);
        n = 0;
        while (prdy !== 1'h1 && n < PU + 10) begin
            @(posedge clk);
            #1 n++;
        end
        chk("powerup", 16'h0001, {15'h0000, n == PU});
        if (prdy !== 1'h1)
            tally_and_finish();
        repeat (3) @(posedge clk);
        #1 chk("irq", 16'h0001, {15'h0000, irq});
        acc(1'h1, 8'h0E, 16'h0000);
        repeat (2) @(posedge clk);
        #1 chk("masked", 16'h0000, {15'h0000, irq});
        acc(1'h1, 8'h0E, 16'h0004);
        acc(1'h0, 8'h0C, 16'h0000);
        chk("status", 16'h0004, v & 16'h0004);
        acc(1'h1, 8'h0C, 16'h0007);
        repeat (2) @(posedge clk);
        #1 chk("cleared", 16'h0000, {15'h0000, irq});
        $display("test interrupts done");
        tally_and_finish();
    end
endmodule // tuner_multifunction_pins_tb
`default_nettype wire
